// ===== rtl/pdm_ctrl.sv
// pulse dimming decoder, pump ratio selector and protection control
//
// The Wishbone register port and the register offsets were left to the implementer.
`timescale 1ns/100ps
`default_nettype none
`include "pdm_defines.svh"
module pdm_ctrl #(
    parameter int unsigned SHUTDOWN_CYCLES = `PDM_SHUTDOWN_CYCLES,
    parameter int unsigned STEP_UP_CYCLES = `PDM_STEP_UP_CYCLES,
    parameter int unsigned SETTLE_CYCLES = `PDM_SETTLE_CYCLES
) (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // classic wishbone slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [3:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    // pins and analog indications
    input wire logic enable_dimming_input_i,
    input wire logic undervoltage_lockout_i,
    input wire logic pump_overvoltage_i,
    input wire logic over_temp_i,
    input wire logic thermal_cool_i,
    input wire logic [2:0] channel_open_i,
    input wire logic [2:0] channel_low_i,
    input wire logic unity_ratio_ok_i,
    // outputs to the analog core
    output logic [2:0] sink_enable_n_o,
    output logic current_set_enable_n_o,
    output logic [10:0] gain_code_o,
    output logic [2:0] gain_index_o,
    output pdm_pkg::pdm_ratio_t ratio_o,
    output logic active_o,
    output logic settling_o
);
    localparam int unsigned FILT = `PDM_FILTER_CYCLES;

    // ----------------------------------------
    // pin synchronisers
    // ----------------------------------------
    logic [11:0] pin_s1_reg, pin_s2_reg;

    // two flops on every asynchronous input, only the second is read
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            pin_s1_reg <= 12'h0;
            pin_s2_reg <= 12'h0;
        end else begin
            pin_s1_reg <= {enable_dimming_input_i, undervoltage_lockout_i, pump_overvoltage_i,
                over_temp_i, thermal_cool_i, channel_open_i, channel_low_i, unity_ratio_ok_i};
            pin_s2_reg <= pin_s1_reg;
        end
    end

    logic pin_s, undervoltage_lockout, ovp, hot, cool, uok_s;
    logic [2:0] open_s, low_s;
    assign {pin_s, undervoltage_lockout, ovp, hot, cool, open_s, low_s, uok_s} = pin_s2_reg;

    // ----------------------------------------
    // deglitch filter on the synchronised pin
    // ----------------------------------------
    logic pin_filt_reg;
    logic [7:0] filt_cnt_reg;

    // a new level must persist for the minimum program time
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            pin_filt_reg <= 1'b0;
            filt_cnt_reg <= 8'h0;
        end else if (pin_s == pin_filt_reg) begin
            filt_cnt_reg <= 8'h0;
        end else if (filt_cnt_reg >= 8'(FILT - 1)) begin
            pin_filt_reg <= pin_s;
            filt_cnt_reg <= 8'h0;
        end else begin
            filt_cnt_reg <= filt_cnt_reg + 8'h1;
        end
    end

    logic pin_prev_reg;
    logic rise;
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            pin_prev_reg <= 1'b0;
        end else begin
            pin_prev_reg <= pin_filt_reg;
        end
    end
    assign rise = pin_filt_reg && !pin_prev_reg;

    // ----------------------------------------
    // timers
    // ----------------------------------------
    pdm_timer_if low_t ();
    pdm_timer_if step_t ();
    pdm_timer_if settle_t ();

    pdm_timer #(.COUNT(SHUTDOWN_CYCLES)) u_low_tmr (
        .clk_i(clk_i), .rst_i(rst_i), .tmr(low_t.timer));
    pdm_timer #(.COUNT(STEP_UP_CYCLES)) u_step_tmr (
        .clk_i(clk_i), .rst_i(rst_i), .tmr(step_t.timer));
    pdm_timer #(.COUNT(SETTLE_CYCLES)) u_settle_tmr (
        .clk_i(clk_i), .rst_i(rst_i), .tmr(settle_t.timer));

    // ----------------------------------------
    // enable, thermal and software control
    // ----------------------------------------
    logic enabled_reg, thermal_reg, sw_en_reg;
    logic run;
    assign low_t.run = enabled_reg && !pin_filt_reg;

    // enable state follows the pin and the shutdown low time
    always_ff @(posedge clk_i) begin
        if (rst_i || undervoltage_lockout) begin
            enabled_reg <= 1'b0;
        end else if (low_t.done) begin
            enabled_reg <= 1'b0;
        end else if (rise) begin
            enabled_reg <= 1'b1;
        end
    end

    // thermal shutdown with hysteresis
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            thermal_reg <= 1'b0;
        end else if (hot) begin
            thermal_reg <= 1'b1;
        end else if (cool) begin
            thermal_reg <= 1'b0;
        end
    end

    assign run = enabled_reg && !thermal_reg && sw_en_reg;

    // ----------------------------------------
    // gain index, modulo six
    // ----------------------------------------
    logic [2:0] gain_idx_reg;
    always_ff @(posedge clk_i) begin
        if (rst_i || !enabled_reg) begin
            gain_idx_reg <= 3'h0;
        end else if (rise) begin
            gain_idx_reg <= (gain_idx_reg == 3'(`PDM_GAIN_LEVELS - 1)) ? 3'h0
                : gain_idx_reg + 3'h1;
        end
    end

    // gain code in eighths, each step halves
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            gain_code_o <= 11'h0;
        end else begin
            gain_code_o <= enabled_reg ? (`PDM_GAIN_FULL >> gain_idx_reg) : 11'h0;
        end
    end

    // settling window after each gain index step, not after the enabling rise
    logic settle_reg;
    assign settle_t.run = settle_reg;
    always_ff @(posedge clk_i) begin
        if (rst_i || !enabled_reg) begin
            settle_reg <= 1'b0;
        end else if (rise) begin
            settle_reg <= 1'b1;
        end else if (settle_t.done) begin
            settle_reg <= 1'b0;
        end
    end

    // ----------------------------------------
    // pump ratio state machine
    // ----------------------------------------
    pdm_pkg::pdm_ratio_t ratio_reg, ratio_next;
    logic [2:0] live;
    logic need_up;
    assign live = ~open_s;
    assign need_up = |(low_s & live);
    assign step_t.run = run && need_up && (ratio_reg != pdm_pkg::PDM_RATIO_2X);

    always_comb begin
        ratio_next = ratio_reg;
        case (ratio_reg)
            pdm_pkg::PDM_RATIO_1X: begin
                if (step_t.done) ratio_next = pdm_pkg::PDM_RATIO_1P33X;
            end
            pdm_pkg::PDM_RATIO_1P33X: begin
                if (step_t.done) ratio_next = pdm_pkg::PDM_RATIO_1P5X;
            end
            pdm_pkg::PDM_RATIO_1P5X: begin
                if (step_t.done) ratio_next = pdm_pkg::PDM_RATIO_2X;
            end
            pdm_pkg::PDM_RATIO_2X: begin
                ratio_next = pdm_pkg::PDM_RATIO_2X;
            end
            default: ratio_next = pdm_pkg::PDM_RATIO_1X;
        endcase
        if (ratio_reg != pdm_pkg::PDM_RATIO_1X && uok_s) begin
            ratio_next = pdm_pkg::PDM_RATIO_1X;
        end
        if (live == 3'h0) begin
            ratio_next = pdm_pkg::PDM_RATIO_1X;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i || !run || ovp) begin
            ratio_reg <= pdm_pkg::PDM_RATIO_1X;
        end else begin
            ratio_reg <= ratio_next;
        end
    end

    // ----------------------------------------
    // output enables to the analog core
    // ----------------------------------------
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            sink_enable_n_o <= 3'h7;
            current_set_enable_n_o <= 1'b1;
        end else begin
            sink_enable_n_o <= ~({3{run}} & live);
            current_set_enable_n_o <= ~run;
        end
    end

    assign gain_index_o = gain_idx_reg;
    assign ratio_o = ratio_reg;
    assign active_o = run;
    assign settling_o = settle_reg;

    // ----------------------------------------
    // wishbone slave: control and status
    // ----------------------------------------
    logic req;
    assign req = wb_cyc_i && wb_stb_i && !wb_ack_o;

    // software enable gates run: sink and current-set enables, active_o and the pump ratio
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            sw_en_reg <= 1'(`PDM_CTRL_RESET_VAL);
        end else if (req && wb_we_i && wb_sel_i[0] && wb_adr_i == `PDM_ADDR_CTRL) begin
            sw_en_reg <= wb_dat_i[`PDM_CTRL_SW_ENABLE];
        end
    end

    // one-wait-state answer, unmapped reads zero
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h0;
        end else begin
            wb_ack_o <= req;
            wb_dat_o <= 32'h0;
            if (req && !wb_we_i) begin
                case (wb_adr_i)
                    `PDM_ADDR_CTRL: wb_dat_o <= {31'h0, sw_en_reg};
                    `PDM_ADDR_STATUS: wb_dat_o <= {13'h0, gain_code_o, ratio_reg,
                        gain_idx_reg, settle_reg, thermal_reg, enabled_reg};
                    default: wb_dat_o <= 32'h0;
                endcase
            end
        end
    end

    // ----------------------------------------
    // checks
    // ----------------------------------------
    sequence s_rise_on;
        rise && enabled_reg;
    endsequence

    a_undervoltage_lockout_shutdown: assert property (@(posedge clk_i) disable iff (rst_i)
        undervoltage_lockout |=> !enabled_reg) else $error("undervoltage did not shut down");
    a_gain_wrap: assert property (@(posedge clk_i) disable iff (rst_i)
        s_rise_on and (gain_idx_reg == 3'h5) |=> gain_idx_reg == 3'h0)
        else $error("gain index did not wrap");
    a_gain_step: assert property (@(posedge clk_i) disable iff (rst_i)
        s_rise_on and (gain_idx_reg < 3'h5) |=> gain_idx_reg == $past(gain_idx_reg) + 3'h1)
        else $error("gain index did not step");
    a_gain_code: assert property (@(posedge clk_i) disable iff (rst_i)
        enabled_reg && $stable(gain_idx_reg) && $stable(enabled_reg)
        |=> gain_code_o == (`PDM_GAIN_FULL >> $past(gain_idx_reg)))
        else $error("gain code wrong");
    a_shutdown_clears: assert property (@(posedge clk_i) disable iff (rst_i)
        low_t.done |=> !enabled_reg ##1 gain_idx_reg == 3'h0)
        else $error("shutdown kept gain");
    a_no_down_step: assert property (@(posedge clk_i) disable iff (rst_i)
        ratio_reg == pdm_pkg::PDM_RATIO_2X |=> ratio_reg inside {pdm_pkg::PDM_RATIO_2X,
        pdm_pkg::PDM_RATIO_1X}) else $error("illegal ratio down step");
    a_all_open_1x: assert property (@(posedge clk_i) disable iff (rst_i)
        live == 3'h0 |=> ratio_reg == pdm_pkg::PDM_RATIO_1X)
        else $error("all open not at 1x");
    a_ovp_restart: assert property (@(posedge clk_i) disable iff (rst_i)
        ovp |=> ratio_reg == pdm_pkg::PDM_RATIO_1X)
        else $error("overvoltage did not restart");
    a_hiz_shutdown: assert property (@(posedge clk_i) disable iff (rst_i)
        !run |=> sink_enable_n_o == 3'h7 && current_set_enable_n_o)
        else $error("outputs driven in shutdown");
    a_thermal_trip: assert property (@(posedge clk_i) disable iff (rst_i)
        hot |=> thermal_reg && !active_o) else $error("thermal trip missed");
endmodule
`default_nettype wire

// ===== rtl/pdm_defines.svh
// timing and encoding constants for the pulse dimming mode control block
`ifndef PDM_DEFINES_SVH
`define PDM_DEFINES_SVH

`define PDM_CLK_MHZ 200
// times in their own units
`define PDM_SHUTDOWN_LOW_TIME_US 1500
`define PDM_PROGRAM_LOW_TIME_MIN_NS 200
`define PDM_STEP_UP_DELAY_US 400
`define PDM_SETTLE_TIME_US 40
// derived cycle counts (least times round up)
`define PDM_SHUTDOWN_CYCLES (`PDM_SHUTDOWN_LOW_TIME_US * `PDM_CLK_MHZ)
`define PDM_FILTER_CYCLES ((`PDM_PROGRAM_LOW_TIME_MIN_NS * `PDM_CLK_MHZ + 999) / 1000)
`define PDM_STEP_UP_CYCLES (`PDM_STEP_UP_DELAY_US * `PDM_CLK_MHZ)
`define PDM_SETTLE_CYCLES (`PDM_SETTLE_TIME_US * `PDM_CLK_MHZ)
// gain index range
`define PDM_GAIN_LEVELS 6
// gain codes in eighths: 132 x 8 = 1056
`define PDM_GAIN_FULL 11'h420
// wishbone register offsets
`define PDM_ADDR_CTRL 4'h0
`define PDM_ADDR_STATUS 4'h4
// control fields
`define PDM_CTRL_SW_ENABLE 0
`define PDM_CTRL_RESET_VAL 32'h0000_0001

`endif

// ===== rtl/pdm_pkg.sv
// types for the pulse dimming mode control block
package pdm_pkg;
    typedef enum logic [1:0] {
        PDM_RATIO_1X = 2'b00,
        PDM_RATIO_1P33X = 2'b01,
        PDM_RATIO_1P5X = 2'b10,
        PDM_RATIO_2X = 2'b11
    } pdm_ratio_t;
endpackage

// ===== rtl/pdm_timer.sv
// qualified-condition timer: counts while run is high, restarts when it drops
`timescale 1ns/100ps
`default_nettype none
module pdm_timer #(
    parameter int unsigned COUNT = 200
) (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // control
    pdm_timer_if.timer tmr
);
    localparam int W = $clog2(COUNT + 1);
    localparam logic [W-1:0] LAST = W'(COUNT - 1);
    logic [W-1:0] cnt_reg;

    // count while qualified, clear when the condition ends or a period is done
    // so a run held high gives one done pulse per full period
    always_ff @(posedge clk_i) begin
        if (rst_i || !tmr.run || tmr.done) begin
            cnt_reg <= '0;
        end else if (cnt_reg != W'(COUNT)) begin
            cnt_reg <= cnt_reg + W'(1);
        end
    end

    assign tmr.done = tmr.run && (cnt_reg >= LAST);
endmodule
`default_nettype wire

// ===== rtl/pdm_timer_if.sv
// interface between the main block and its delay timers
`timescale 1ns/100ps
`default_nettype none
interface pdm_timer_if;
    logic run;
    logic done;
    modport owner (output run, input done);
    modport timer (input run, output done);
endinterface
`default_nettype wire

// ===== sim/pdm_host_model.sv
// host processor pin driver for the enable/dimming input
`timescale 1ns/100ps
`default_nettype none
module pdm_host_model (
    // clock
    input wire logic clk_i,
    // pin
    output logic pin_o
);
    // ----------------------------------------
    // pin sequences
    // ----------------------------------------
    initial pin_o = 1'b0;

    // raise from shutdown, hold off before any dimming pulse
    task automatic enable();
        @(posedge clk_i);
        pin_o <= 1'b1;
        repeat (2000) @(posedge clk_i);
    endtask

    // one low pulse followed by a high phase
    task automatic pulse(input int lo, input int hi);
        @(posedge clk_i);
        pin_o <= 1'b0;
        repeat (lo) @(posedge clk_i);
        pin_o <= 1'b1;
        repeat (hi) @(posedge clk_i);
    endtask

    // long low that parks the device in shutdown
    task automatic park(input int lo);
        @(posedge clk_i);
        pin_o <= 1'b0;
        repeat (lo) @(posedge clk_i);
    endtask
endmodule
`default_nettype wire

// ===== sim/tb_pulse_dimming_mode_control.sv
// self-checking bench for the pulse dimming mode control block
`timescale 1ns/100ps
`default_nettype none
`include "pdm_defines.svh"
module tb_pulse_dimming_mode_control;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic wb_cyc = 1'b0, wb_stb = 1'b0, wb_we = 1'b0;
    logic [3:0] wb_adr = 4'h0, wb_sel = 4'h0;
    logic [31:0] wb_wdat = 32'h0, wb_rdat, rd;
    logic wb_ack, pin, undervoltage_lockout = 1'b0, ovp = 1'b0, hot = 1'b0, cool = 1'b0, ok1x = 1'b0;
    logic [2:0] ch_open = 3'h0, ch_low = 3'h0, sink_n, idx;
    logic set_n, active, settling;
    logic [10:0] gain;
    pdm_pkg::pdm_ratio_t ratio;
    int n_fail = 0, checks_done = 0;

    // 200 mhz clock
    initial forever #2.5 clk_i = ~clk_i;

    pdm_host_model host (.clk_i(clk_i), .pin_o(pin));

    pdm_ctrl #(.SHUTDOWN_CYCLES(500), .STEP_UP_CYCLES(200), .SETTLE_CYCLES(100)) DUT (
        .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb),
        .wb_we_i(wb_we), .wb_adr_i(wb_adr), .wb_sel_i(wb_sel), .wb_dat_i(wb_wdat),
        .wb_dat_o(wb_rdat), .wb_ack_o(wb_ack), .enable_dimming_input_i(pin),
        .undervoltage_lockout_i(undervoltage_lockout), .pump_overvoltage_i(ovp), .over_temp_i(hot),
        .thermal_cool_i(cool), .channel_open_i(ch_open), .channel_low_i(ch_low),
        .unity_ratio_ok_i(ok1x), .sink_enable_n_o(sink_n), .current_set_enable_n_o(set_n),
        .gain_code_o(gain), .gain_index_o(idx), .ratio_o(ratio), .active_o(active),
        .settling_o(settling));

    // ----------------------------------------
    // helpers
    // ----------------------------------------
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            n_fail++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic complete_run();
        $display("checks=%0d fails=%0d", checks_done, n_fail);
        if (n_fail == 0 && checks_done > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    task automatic cycles(input int n);
        repeat (n) @(posedge clk_i);
    endtask

    // classic single wishbone cycle, held until ack is sampled
    task automatic wb_xfer(input logic w, input logic [3:0] a, input logic [3:0] s,
                           input logic [31:0] d, output logic [31:0] q);
        int n;
        n = 0;
        @(posedge clk_i);
        wb_cyc <= 1'b1;
        wb_stb <= 1'b1;
        wb_we <= w;
        wb_adr <= a;
        wb_sel <= s;
        wb_wdat <= d;
        do begin
            @(posedge clk_i);
            n++;
        end while (wb_ack !== 1'b1);
        chk(n, 2); // ack one cycle after the request is taken
        q = wb_rdat;
        wb_cyc <= 1'b0;
        wb_stb <= 1'b0;
        wb_we <= 1'b0;
    endtask

    task automatic rd_chk(input logic [3:0] a, input logic [31:0] exp);
        logic [31:0] q;
        wb_xfer(1'b0, a, 4'hf, 32'h0, q);
        chk(q, exp);
    endtask

    // wait for the next pump ratio, no earlier than the step delay
    task automatic step_to(input logic [1:0] r);
        int n;
        n = 0;
        while (ratio !== r && n < 400) begin
            @(posedge clk_i);
            n++;
        end
        chk(n >= 190 && n < 400, 1'b1);
        if (n >= 400) begin
            complete_run();
        end
    endtask

    // ----------------------------------------
    // stimulus
    // ----------------------------------------
    initial begin
        repeat (4) @(posedge clk_i);
        rst_i <= 1'b0;
        chk({sink_n, set_n, active}, 5'h1e);
        chk(gain, 11'h000);
        rd_chk(`PDM_ADDR_STATUS, 32'h0);
        rd_chk(`PDM_ADDR_CTRL, `PDM_CTRL_RESET_VAL);
        rd_chk(4'h8, 32'h0);
        // first rise enables at full gain
        host.enable();
        chk({sink_n, set_n, active}, 5'h01);
        rd_chk(`PDM_ADDR_STATUS, {13'h0, `PDM_GAIN_FULL, 8'h01});
        host.pulse(10, 60);
        chk(idx, 3'h0);
        // gain cycling through all six levels and wrapping
        for (int k = 1; k <= 7; k++) begin
            host.pulse(60, 60);
            chk(idx, k % 6);
            chk(gain, `PDM_GAIN_FULL >> (k % 6));
        end
        chk(settling, 1'b1);
        cycles(150);
        chk(settling, 1'b0);
        host.pulse(400, 60);
        chk({active, idx}, 4'ha);
        // ratio climb and direct return
        ch_low <= 3'h1;
        step_to(2'h1);
        step_to(2'h2);
        step_to(2'h3);
        cycles(300);
        chk(ratio, 2'h3);
        ok1x <= 1'b1;
        cycles(5);
        chk(ratio, 2'h0);
        ok1x <= 1'b0;
        ch_open <= 3'h1;
        cycles(400);
        chk(ratio, 2'h0);
        ch_open <= 3'h2;
        step_to(2'h1);
        ch_open <= 3'h7;
        cycles(5);
        chk(ratio, 2'h0);
        ch_open <= 3'h0;
        step_to(2'h1);
        ovp <= 1'b1;
        cycles(5);
        chk(ratio, 2'h0);
        ovp <= 1'b0;
        ch_low <= 3'h0;
        // thermal trip and recovery
        hot <= 1'b1;
        cycles(5);
        chk(active, 1'b0);
        hot <= 1'b0;
        cycles(10);
        chk(active, 1'b0);
        cool <= 1'b1;
        cycles(5);
        chk(active, 1'b1);
        cool <= 1'b0;
        // software enable, byte select and unmapped write
        wb_xfer(1'b1, `PDM_ADDR_CTRL, 4'h0, 32'h0, rd);
        wb_xfer(1'b1, 4'h8, 4'hf, 32'h0, rd);
        cycles(2);
        chk(active, 1'b1);
        wb_xfer(1'b1, `PDM_ADDR_CTRL, 4'h1, 32'h0, rd);
        cycles(2);
        chk(active, 1'b0);
        rd_chk(`PDM_ADDR_CTRL, 32'h0);
        wb_xfer(1'b1, `PDM_ADDR_CTRL, 4'h1, 32'h1, rd);
        // undervoltage lockout, re-enable on a new rise
        undervoltage_lockout <= 1'b1;
        cycles(5);
        chk({sink_n, set_n, active, gain}, 16'hf000);
        undervoltage_lockout <= 1'b0;
        cycles(10);
        chk(active, 1'b0);
        host.pulse(60, 60);
        chk({active, idx}, 4'h8);
        // long low discards gain and shuts down
        host.pulse(60, 60);
        host.park(700);
        chk({sink_n, set_n, active, gain}, 16'hf000);
        host.enable();
        chk({idx, gain}, {3'h0, `PDM_GAIN_FULL});
        complete_run();
    end

    // hang guard
    initial begin
        repeat (100000) @(posedge clk_i);
        n_fail++;
        complete_run();
    end
endmodule
`default_nettype wire
